// File: design/slave_port_memory_map.sv
// Control-port address decoder: steers accesses to paged memories and registers.
// Assumes targets answer reads combinationally in the strobe cycle.
module slave_port_memory_map #(
    parameter int DMA_AW = 14,
    parameter int DMB_AW = 14,
    parameter int PS_AW = 13
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic cp_req,
    input wire logic cp_we,
    input wire logic [15:0] cp_addr,
    input wire logic [31:0] cp_wdata,
    output logic cp_rvalid,
    output logic [31:0] cp_rdata,
    input wire logic page_a,
    input wire logic page_b,
    input wire logic page_ps,
    input wire logic core_stopped,
    output logic dma_sel,
    output logic dma_we,
    output logic dma_page,
    output logic [DMA_AW-1:0] dma_addr,
    input wire logic [31:0] dma_rdata,
    output logic dmb_sel,
    output logic dmb_we,
    output logic dmb_page,
    output logic [DMB_AW-1:0] dmb_addr,
    input wire logic [31:0] dmb_rdata,
    output logic ps_sel,
    output logic ps_we,
    output logic ps_page,
    output logic [PS_AW-1:0] ps_addr,
    input wire logic [31:0] ps_rdata,
    output logic [31:0] mem_wdata,
    input wire logic loop_locked,
    input wire logic [slave_map_pkg::CLKOUT_W-1:0] clkout_state,
    output logic [slave_map_pkg::FB_DIV_W-1:0] fb_divider,
    output logic [slave_map_pkg::IN_DIV_W-1:0] in_divider,
    output logic ref_source,
    output logic loop_enable
);
    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo,
                                      input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction

    logic lock_s1_q;
    logic lock_s2_q;
    logic rvalid_q;
    logic [31:0] rdata_q;
    logic [15:0] reg_rdata;

    wire hit_a = in_range(cp_addr, slave_map_pkg::DMA_LO, slave_map_pkg::DMA_HI);
    wire hit_b = in_range(cp_addr, slave_map_pkg::DMB_LO, slave_map_pkg::DMB_HI);
    wire hit_ps = in_range(cp_addr, slave_map_pkg::PS_LO, slave_map_pkg::PS_HI);
    wire hit_reg = in_range(cp_addr, slave_map_pkg::REG_LO, slave_map_pkg::REG_HI);
    // A running core keeps the program store out of reach; the access falls to unmapped
    wire ps_ok = hit_ps && core_stopped;
    wire [15:0] ofs_b = cp_addr - slave_map_pkg::DMB_LO;
    wire [15:0] ofs_ps = cp_addr - slave_map_pkg::PS_LO;
    // The constant table range matches nothing above, so it decodes as unmapped
    wire reg_wr = cp_req && cp_we && hit_reg;

    assign dma_sel = cp_req && hit_a;
    assign dmb_sel = cp_req && hit_b;
    assign ps_sel = cp_req && ps_ok;
    assign dma_we = dma_sel && cp_we;
    assign dmb_we = dmb_sel && cp_we;
    assign ps_we = ps_sel && cp_we;
    // Same range for both pages; the outside page input picks the storage
    assign dma_page = page_a;
    assign dmb_page = page_b;
    assign ps_page = page_ps;
    assign dma_addr = cp_addr[DMA_AW-1:0];
    assign dmb_addr = ofs_b[DMB_AW-1:0];
    assign ps_addr = ofs_ps[PS_AW-1:0];
    assign mem_wdata = cp_wdata;

    // Unmapped reads return zero, writes reach no target
    wire [31:0] rd_mux = hit_a ? dma_rdata :
                         hit_b ? dmb_rdata :
                         ps_ok ? ps_rdata :
                         hit_reg ? {16'h0000, reg_rdata} :
                         32'h0000_0000;

    // The lock flag comes from analog logic on no clock of ours
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lock_s1_q <= 1'b0;
            lock_s2_q <= 1'b0;
        end else begin
            lock_s1_q <= loop_locked;
            lock_s2_q <= lock_s1_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rvalid_q <= cp_req && !cp_we;
            if (cp_req && !cp_we) rdata_q <= rd_mux;
        end
    end

    assign cp_rvalid = rvalid_q;
    assign cp_rdata = rdata_q;

    loop_ctl_regs u_regs (
        .clk(clk),
        .rst(rst),
        .wr_en(reg_wr),
        .addr(cp_addr),
        .wdata(cp_wdata[15:0]),
        .lock_in(lock_s2_q),
        .clkout_state(clkout_state),
        .rdata(reg_rdata),
        .fb_divider(fb_divider),
        .in_divider(in_divider),
        .ref_source(ref_source),
        .loop_enable(loop_enable)
    );

    property p_bank_a_range;
        @(posedge clk) disable iff (rst)
        dma_sel == (cp_req && cp_addr <= 16'h2FFF);
    endproperty
    a_bank_a_range: assert property (p_bank_a_range)
        else $error("bank A decode wrong");

    property p_bank_a_page;
        @(posedge clk) disable iff (rst)
        dma_sel |-> (dma_page == page_a) && (dma_addr == cp_addr[DMA_AW-1:0]);
    endproperty
    a_bank_a_page: assert property (p_bank_a_page)
        else $error("bank A page wrong");

    property p_bank_b_range;
        @(posedge clk) disable iff (rst)
        dmb_sel == (cp_req && cp_addr >= 16'h6000 && cp_addr <= 16'h8FFF);
    endproperty
    a_bank_b_range: assert property (p_bank_b_range)
        else $error("bank B decode wrong");

    property p_bank_b_page;
        @(posedge clk) disable iff (rst)
        dmb_sel |-> (dmb_page == page_b) && ({2'b00, dmb_addr} + 16'h6000 == cp_addr);
    endproperty
    a_bank_b_page: assert property (p_bank_b_page)
        else $error("bank B offset wrong");

    property p_ps_range;
        @(posedge clk) disable iff (rst)
        ps_sel |-> cp_addr >= 16'hC000 && cp_addr <= 16'hDFFF
                   && ({3'b000, ps_addr} + 16'hC000 == cp_addr);
    endproperty
    a_ps_range: assert property (p_ps_range)
        else $error("program store decode wrong");

    property p_ps_page;
        @(posedge clk) disable iff (rst)
        ps_sel |-> ps_page == page_ps;
    endproperty
    a_ps_page: assert property (p_ps_page)
        else $error("program store page wrong");

    property p_ps_stopped;
        @(posedge clk) disable iff (rst)
        (cp_req && !cp_we && !core_stopped && cp_addr >= 16'hC000 && cp_addr <= 16'hDFFF)
        |-> !ps_sel ##1 (cp_rvalid && cp_rdata == 32'h0000_0000);
    endproperty
    a_ps_stopped: assert property (p_ps_stopped)
        else $error("program store reached while running");

    property p_lut_hidden;
        @(posedge clk) disable iff (rst)
        (cp_req && cp_addr >= 16'hE000 && cp_addr <= 16'hEFFF)
        |-> !(dma_sel || dmb_sel || ps_sel || reg_wr);
    endproperty
    a_lut_hidden: assert property (p_lut_hidden)
        else $error("constant table reachable");

    property p_reg_write;
        @(posedge clk) disable iff (rst)
        (cp_req && cp_we && cp_addr == 16'hF003) |=> loop_enable == $past(cp_wdata[0]);
    endproperty
    a_reg_write: assert property (p_reg_write)
        else $error("register write lost");

    property p_reg_width;
        @(posedge clk) disable iff (rst)
        (cp_req && !cp_we && cp_addr >= 16'hF000 && cp_addr <= 16'hFBFF)
        |=> cp_rvalid && cp_rdata[31:16] == 16'h0000;
    endproperty
    a_reg_width: assert property (p_reg_width)
        else $error("register read wider than 16 bits");

    property p_unmapped;
        @(posedge clk) disable iff (rst)
        (cp_req && !cp_we && ((cp_addr >= 16'h3000 && cp_addr <= 16'h5FFF)
                              || cp_addr >= 16'hFC00))
        |=> cp_rvalid && cp_rdata == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    // Every read, mapped or not, is answered exactly one cycle later
    property p_read_answer;
        @(posedge clk) disable iff (rst)
        (cp_req && !cp_we) |=> cp_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer missing");

    property p_read_idle;
        @(posedge clk) disable iff (rst)
        !(cp_req && !cp_we) |=> !cp_rvalid;
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read answer without a read");

    property p_page_follow;
        @(posedge clk) disable iff (rst)
        dmb_sel && $changed(page_b) |-> dmb_page == page_b;
    endproperty
    a_page_follow: assert property (p_page_follow)
        else $error("page not from input");
endmodule

// File: design/slave_map_pkg.sv
// Constants for the control-port address decoder and its loop-control registers.
// Assumes 16-bit control-port word addresses and one 125 MHz system clock.
package slave_map_pkg;
    localparam logic [15:0] DMA_LO = 16'h0000;
    localparam logic [15:0] DMA_HI = 16'h2FFF;
    localparam logic [15:0] DMB_LO = 16'h6000;
    localparam logic [15:0] DMB_HI = 16'h8FFF;
    localparam logic [15:0] PS_LO = 16'hC000;
    localparam logic [15:0] PS_HI = 16'hDFFF;
    localparam logic [15:0] LUT_LO = 16'hE000;
    localparam logic [15:0] LUT_HI = 16'hEFFF;
    localparam logic [15:0] REG_LO = 16'hF000;
    localparam logic [15:0] REG_HI = 16'hFBFF;

    localparam logic [15:0] OFS_FB_DIV = 16'hF000;
    localparam logic [15:0] OFS_IN_DIV = 16'hF001;
    localparam logic [15:0] OFS_REF_SRC = 16'hF002;
    localparam logic [15:0] OFS_PWR_ON = 16'hF003;
    localparam logic [15:0] OFS_LOCK = 16'hF004;
    localparam logic [15:0] OFS_CLKOUT = 16'hF005;

    localparam logic [15:0] RST_FB_DIV = 16'h0060;
    localparam logic [15:0] RST_IN_DIV = 16'h0000;
    localparam logic [15:0] RST_REF_SRC = 16'h0000;
    localparam logic [15:0] RST_PWR_ON = 16'h0000;

    localparam int FB_DIV_W = 7;
    localparam int IN_DIV_W = 2;
    localparam int CLKOUT_W = 3;
    localparam int REG_W = 16;
endpackage

// File: design/loop_ctl_regs.sv
// Loop-control register file in the control-register window.
// Assumes one-cycle write strobes from the decoder; lock input already synchronised.
module loop_ctl_regs (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [15:0] addr,
    input wire logic [15:0] wdata,
    input wire logic lock_in,
    input wire logic [slave_map_pkg::CLKOUT_W-1:0] clkout_state,
    output logic [15:0] rdata,
    output logic [slave_map_pkg::FB_DIV_W-1:0] fb_divider,
    output logic [slave_map_pkg::IN_DIV_W-1:0] in_divider,
    output logic ref_source,
    output logic loop_enable
);
    logic [slave_map_pkg::FB_DIV_W-1:0] fb_q;
    logic [slave_map_pkg::IN_DIV_W-1:0] in_q;
    logic ref_q;
    logic pwr_q;
    wire hit_fb = addr == slave_map_pkg::OFS_FB_DIV;
    wire hit_in = addr == slave_map_pkg::OFS_IN_DIV;
    wire hit_ref = addr == slave_map_pkg::OFS_REF_SRC;
    wire hit_pwr = addr == slave_map_pkg::OFS_PWR_ON;
    wire hit_lock = addr == slave_map_pkg::OFS_LOCK;
    wire hit_clk = addr == slave_map_pkg::OFS_CLKOUT;

    // Only the defined fields are stored; reserved bits read as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fb_q <= slave_map_pkg::RST_FB_DIV[slave_map_pkg::FB_DIV_W-1:0];
            in_q <= slave_map_pkg::RST_IN_DIV[slave_map_pkg::IN_DIV_W-1:0];
            ref_q <= slave_map_pkg::RST_REF_SRC[0];
            pwr_q <= slave_map_pkg::RST_PWR_ON[0];
        end else if (wr_en) begin
            if (hit_fb) fb_q <= wdata[slave_map_pkg::FB_DIV_W-1:0];
            if (hit_in) in_q <= wdata[slave_map_pkg::IN_DIV_W-1:0];
            if (hit_ref) ref_q <= wdata[0];
            if (hit_pwr) pwr_q <= wdata[0];
        end
    end

    // Unused register addresses in the window read zero
    assign rdata = hit_fb ? {{(16-slave_map_pkg::FB_DIV_W){1'b0}}, fb_q} :
                   hit_in ? {{(16-slave_map_pkg::IN_DIV_W){1'b0}}, in_q} :
                   hit_ref ? {15'h0000, ref_q} :
                   hit_pwr ? {15'h0000, pwr_q} :
                   hit_lock ? {15'h0000, lock_in} :
                   hit_clk ? {{(16-slave_map_pkg::CLKOUT_W){1'b0}}, clkout_state} :
                   16'h0000;
    assign fb_divider = fb_q;
    assign in_divider = in_q;
    assign ref_source = ref_q;
    assign loop_enable = pwr_q;
endmodule

// File: verification/paged_mem_model.sv
// Paged target storage standing in for both data banks and the program store.
// Assumes strobes, pages and word offsets from the decoder, sampled on clk.
module paged_mem_model (
    input wire logic clk,
    input wire logic [2:0] sel,
    input wire logic [2:0] we,
    input wire logic [2:0] page,
    input wire logic [3:0] off0,
    input wire logic [3:0] off1,
    input wire logic [3:0] off2,
    input wire logic [31:0] wdata,
    output logic [31:0] rdata0,
    output logic [31:0] rdata1,
    output logic [31:0] rdata2
);
    timeunit 1ns;
    timeprecision 1ps;
    // Only 16 words a page: enough to tell pages and range ends apart
    logic [31:0] mem [3][2][16];
    logic [2:0][3:0] off;
    logic tog = 1'b0;
    assign off = {off2, off1, off0};
    always @(posedge clk) begin
        tog <= ~tog;
        for (int i = 0; i < 3; i++) begin
            if (sel[i] && we[i]) begin
                mem[i][page[i]][off[i]] <= wdata;
            end
        end
    end
    // Unselected targets show a changing pattern, so stale data cannot pass
    assign rdata0 = sel[0] ? mem[0][page[0]][off0] : {32{tog}};
    assign rdata1 = sel[1] ? mem[1][page[1]][off1] : {32{tog}};
    assign rdata2 = sel[2] ? mem[2][page[2]][off2] : {32{tog}};
endmodule

// File: verification/test_slave_port_memory_map.sv
// Self-checking bench for the control-port decoder and its loop registers.
// Assumes the paged target model answers reads in the strobe cycle.
module test_slave_port_memory_map;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst = 1, req = 0, we = 0, lock = 0, stopped = 1;
    logic [15:0] addr = 16'h0000;
    logic [31:0] wd = 32'h0, mwd, rd0, rd1, rd2, rdata;
    logic [2:0] pg = 3'h0, cko = 3'h0;
    wire [2:0] sel, wen, pgo;
    logic [13:0] aa, ab;
    logic [12:0] ap;
    logic rvalid, ref_src, en;
    logic [6:0] fb;
    logic [1:0] ind;
    int failures = 0, n_compared = 0;
    logic [15:0] base [3] = '{16'h0000, 16'h6000, 16'hC000};
    logic [15:0] top [3] = '{16'h2FFF, 16'h8FFF, 16'hDFFF};
    logic [15:0] um [10] = '{16'h3000, 16'h5FFF, 16'h9000, 16'hBFFF, 16'hE000,
        16'hEFFF, 16'hF006, 16'hFBFF, 16'hFC00, 16'hFFFF};
    logic [31:0] rr [6] = '{32'h60, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    always #4 clk = ~clk;

    slave_port_memory_map slave_port_memory_map_inst (.clk(clk), .rst(rst), .cp_req(req),
        .cp_we(we), .cp_addr(addr), .cp_wdata(wd), .cp_rvalid(rvalid), .cp_rdata(rdata),
        .page_a(pg[0]), .page_b(pg[1]), .page_ps(pg[2]), .core_stopped(stopped),
        .dma_sel(sel[0]), .dma_we(wen[0]), .dma_page(pgo[0]), .dma_addr(aa), .dma_rdata(rd0),
        .dmb_sel(sel[1]), .dmb_we(wen[1]), .dmb_page(pgo[1]), .dmb_addr(ab), .dmb_rdata(rd1),
        .ps_sel(sel[2]), .ps_we(wen[2]), .ps_page(pgo[2]), .ps_addr(ap), .ps_rdata(rd2),
        .mem_wdata(mwd), .loop_locked(lock), .clkout_state(cko), .fb_divider(fb),
        .in_divider(ind), .ref_source(ref_src), .loop_enable(en));
    paged_mem_model paged_mem_model_inst (.clk(clk), .sel(sel), .we(wen), .page(pgo),
        .off0(aa[3:0]), .off1(ab[3:0]), .off2(ap[3:0]), .wdata(mwd), .rdata0(rd0),
        .rdata1(rd1), .rdata2(rd2));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic test_done();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // One access with an idle cycle after it, so req is never set twice in one step
    task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
        input logic [31:0] e);
        logic [2:0] es;
        es[0] = a <= 16'h2FFF;
        es[1] = a >= 16'h6000 && a <= 16'h8FFF;
        es[2] = a >= 16'hC000 && a <= 16'hDFFF && stopped;
        we = w;
        addr = a;
        wd = d;
        req = 1;
        #1 check("strobes", {26'h0, wen, sel}, {26'h0, w ? es : 3'h0, es});
        @(posedge clk);
        #1 req = 0;
        check("rvalid", {31'h0, rvalid}, {31'h0, !w});
        if (!w) check("rdata", rdata, e);
        @(posedge clk);
        #1;
    endtask

    initial begin
        #100000;
        failures++;
        test_done();
    end

    initial begin
        repeat (10) @(posedge clk);
        check("reset fields", {16'h0, en, ref_src, ind, 5'h0, fb}, 32'h0060);
        check("reset rdata", rdata, 32'h0);
        check("reset rvalid", {31'h0, rvalid}, 32'h0);
        #1 rst = 0;
        foreach (rr[i]) acc(0, 16'hF000 + 16'(i), 0, rr[i]);
        acc(1, 16'hF000, 32'hFFFF_FFFF, 0);
        acc(1, 16'hF001, 32'h3, 0);
        acc(1, 16'hF002, 32'h1, 0);
        acc(1, 16'hF003, 32'h1, 0);
        check("fields", {16'h0, en, ref_src, ind, 5'h0, fb}, 32'hF07F);
        acc(0, 16'hF000, 0, 32'h7F);
        acc(0, 16'hF001, 0, 32'h3);
        cko = 3'h5;
        lock = 1;
        repeat (3) @(posedge clk);
        #1 acc(1, 16'hF004, 0, 0);
        acc(1, 16'hF005, 0, 0);
        acc(0, 16'hF004, 0, 32'h1);
        acc(0, 16'hF005, 0, 32'h5);
        for (int i = 0; i < 3; i++) begin
            pg[i] = 0;
            acc(1, base[i] + 16'h5, 32'h1111_0000 + i, 0);
            acc(1, top[i], 32'h3333_0000 + i, 0);
            pg[i] = 1;
            acc(1, base[i] + 16'h5, 32'h2222_0000 + i, 0);
            acc(0, base[i] + 16'h5, 0, 32'h2222_0000 + i);
            pg[i] = 0;
            acc(0, base[i] + 16'h5, 0, 32'h1111_0000 + i);
            acc(0, top[i], 0, 32'h3333_0000 + i);
        end
        foreach (um[i]) begin
            acc(1, um[i], 32'hFFFF_FFFF, 0);
            acc(0, um[i], 0, 0);
        end
        // Unmapped writes alias onto each bank's last word if high address bits are ignored
        foreach (top[i]) acc(0, top[i], 0, 32'h3333_0000 + i);
        acc(0, 16'hF000, 0, 32'h7F);
        stopped = 0;
        acc(1, 16'hC005, 32'hDEAD_0001, 0);
        acc(0, 16'hC005, 0, 0);
        stopped = 1; // The master halts the core before touching program store
        acc(0, 16'hC005, 0, 32'h1111_0002);
        test_done();
    end
endmodule
